// ==== src/epoc_top.sv ====
// top of the discrete output and indicator controller with its apb register file
// assumes apb master on i_core_clk; energy increments, demand ends and alarms are
// synchronous strobes; hold state is kept in an external retentive store
module epoc_top
  import epoc_pkg::*;
#(
  parameter int          N_ALM       = 16,
  parameter bit          IND_FORCED  = 1'b0,
  parameter int unsigned SEC_CYC     = SEC_CYCLES
)
(
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  // register bus
  input  epoc_pkg::epoc_apb_req_t i_apb,
  output epoc_pkg::epoc_apb_rsp_t o_apb,
  // metering events
  input  epoc_pkg::epoc_nrg_t    i_nrg,
  input  wire logic [2:0]        i_dmd_end,
  input  wire logic [N_ALM-1:0]  i_alm,
  // retentive hold store
  input  wire logic              i_hold_valid,
  input  wire logic              i_hold_saved,
  output logic                   o_hold_state,
  // pins
  output logic                   o_dout,
  output logic                   o_led
);

  import epoc_pkg::*;

  // parameter checks at elaboration
  if (N_ALM < 1 || N_ALM > 32)
  begin : g_bad_alm
    $error("N_ALM out of range");
  end
  if (SEC_CYC < 1)
  begin : g_bad_sec
    $error("SEC_CYC must be positive");
  end

  typedef struct packed {
    logic [11:0]      out_cfg;
    logic [13:0]      on_time;
    logic [N_ALM-1:0] alm_sel;
    logic [7:0]       ind_cfg;
    logic [31:0]      ind_rate;
    logic [31:0]      unit;
    logic             out_on;
    logic             restored;
    logic [13:0]      sec_left;
    logic [31:0]      tick;
    logic [23:0]      dmd_cnt;
    logic             alm_q;
    logic [31:0]      prdata;
  } epoc_st_t;

  epoc_st_t st_ff, nxt_st;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // channel select; codes 0..8 in the documented order, others give zero
  function automatic logic [16:0] chan_inc(input logic [3:0] ch, input epoc_nrg_t n);
    logic [16:0] r;
    r = '0;
    case (ch)
      4'h0: r = {1'b0, n.act_del};
      4'h1: r = {1'b0, n.act_rec};
      4'h2: r = 17'(n.act_del) + 17'(n.act_rec);
      4'h3: r = {1'b0, n.rea_del};
      4'h4: r = {1'b0, n.rea_rec};
      4'h5: r = 17'(n.rea_del) + 17'(n.rea_rec);
      4'h6: r = {1'b0, n.app_del};
      4'h7: r = {1'b0, n.app_rec};
      4'h8: r = 17'(n.app_del) + 17'(n.app_rec);
      default: r = '0;
    endcase
    return r;
  endfunction : chan_inc

  function automatic logic [31:0] clamp_rate(input logic [31:0] v);
    if (v < 32'(RATE_MIN)) return 32'(RATE_MIN);
    if (v > 32'(RATE_MAX)) return 32'(RATE_MAX);
    return v;
  endfunction : clamp_rate

  // ----------------------------------------------------------------
  // decoded configuration
  // ----------------------------------------------------------------
  epoc_src_t  src;
  epoc_beh_t  beh;
  epoc_ind_t  ind_mode;
  logic [1:0] dmd_sys;
  logic       wr, rd;
  logic       cmd_on, cmd_off;
  logic       dmd_hit, alm_hit;
  logic       dout_pulse, led_pulse;
  logic       led_nrg;
  logic       o_dout_i;
  logic       paddr_ok;

  assign src      = epoc_src_t'(st_ff.out_cfg[OCFG_SRC_LSB +: 2]);
  assign beh      = epoc_beh_t'(st_ff.out_cfg[OCFG_BEH_LSB +: 2]);
  assign dmd_sys  = st_ff.out_cfg[OCFG_DMD_LSB +: 2];
  assign ind_mode = IND_FORCED ? IND_NRG : epoc_ind_t'(st_ff.ind_cfg[ICFG_MODE_LSB +: 2]);
  assign led_nrg  = (ind_mode == IND_NRG);
  assign wr       = i_apb.psel && i_apb.penable && i_apb.pwrite;
  assign rd       = i_apb.psel && !i_apb.pwrite && !i_apb.penable;
  assign cmd_on   = wr && i_apb.paddr[7:0] == ADDR_OUT_CMD && i_apb.pwdata[CMD_ON_BIT];
  assign cmd_off  = wr && i_apb.paddr[7:0] == ADDR_OUT_CMD && i_apb.pwdata[CMD_OFF_BIT];
  // at most one demand system is followed; code 3 follows none
  assign dmd_hit  = (dmd_sys < 2'h3) && i_dmd_end[dmd_sys];
  // any selected alarm condition triggers the output
  assign alm_hit  = |(i_alm & st_ff.alm_sel);

  // ----------------------------------------------------------------
  // energy pulse generators for the output and the indicator
  // ----------------------------------------------------------------
  epoc_pulse_gen #(.ACC_W(48)) u_dout_pg
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_en       (src == SRC_NRG),
    .i_rate     (clamp_rate(st_ff.ind_rate)),
    .i_unit     (st_ff.unit),
    .i_inc      (chan_inc(st_ff.out_cfg[OCFG_CH_LSB +: 4], i_nrg)),
    .o_pulse    (dout_pulse)
  );

  // in alarm mode the generator is held off, so rate and channel do nothing
  epoc_pulse_gen #(.ACC_W(48)) u_led_pg
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_en       (led_nrg),
    .i_rate     (clamp_rate(st_ff.ind_rate)),
    .i_unit     (st_ff.unit),
    .i_inc      (chan_inc(st_ff.ind_cfg[ICFG_CH_LSB +: 4], i_nrg)),
    .o_pulse    (led_pulse)
  );

  // ----------------------------------------------------------------
  // next state: register file and output behaviour
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.alm_q   = alm_hit;
    // register writes
    if (wr)
    begin
      if (i_apb.paddr[7:0] == ADDR_OUT_CFG)
        nxt_st.out_cfg = i_apb.pwdata[11:0];
      else if (i_apb.paddr[7:0] == ADDR_ON_TIME)
        nxt_st.on_time = (i_apb.pwdata[13:0] > 14'(ON_TIME_MAX_S)) ? 14'(ON_TIME_MAX_S)
                                                                   : i_apb.pwdata[13:0];
      else if (i_apb.paddr[7:0] == ADDR_ALM_SEL)
        nxt_st.alm_sel = i_apb.pwdata[N_ALM-1:0];
      else if (i_apb.paddr[7:0] == ADDR_IND_CFG)
        nxt_st.ind_cfg = i_apb.pwdata[7:0];
      else if (i_apb.paddr[7:0] == ADDR_IND_RATE)
        nxt_st.ind_rate = clamp_rate(i_apb.pwdata);
      else if (i_apb.paddr[7:0] == ADDR_UNIT)
        nxt_st.unit = (i_apb.pwdata == 32'h0) ? 32'h1 : i_apb.pwdata;
    end
    // one-second tick for the timed behaviour
    if (st_ff.tick == 32'(SEC_CYC - 1))
      nxt_st.tick = '0;
    else
      nxt_st.tick = st_ff.tick + 32'h1;
    if (st_ff.dmd_cnt != 24'h0)
      nxt_st.dmd_cnt = st_ff.dmd_cnt - 24'h1;
    // restore the retained hold state once after reset; waits for the hold
    // configuration, since the register file itself comes up latched
    if (!st_ff.restored && i_hold_valid && beh == BEH_HOLD && (src == SRC_EXT || src == SRC_ALM))
    begin
      nxt_st.restored = 1'b1;
      nxt_st.out_on   = i_hold_saved;
    end
    case (src)
      SRC_EXT, SRC_ALM:
      begin
        // turn-on event: remote command, or a rising selected alarm
        if (cmd_on || (src == SRC_ALM && alm_hit && !st_ff.alm_q))
        begin
          nxt_st.out_on   = 1'b1;
          nxt_st.sec_left = st_ff.on_time;
          nxt_st.tick     = '0;
        end
        else if (cmd_off)
          nxt_st.out_on = 1'b0;
        else if (beh == BEH_TIMED && st_ff.out_on && st_ff.tick == 32'(SEC_CYC - 1))
        begin
          if (st_ff.sec_left <= 14'h1)
            nxt_st.out_on = 1'b0;
          nxt_st.sec_left = (st_ff.sec_left == 14'h0) ? 14'h0 : st_ff.sec_left - 14'h1;
        end
        if (beh == BEH_TIMED && (cmd_on || alm_hit) && st_ff.on_time == 14'h0)
          nxt_st.out_on = 1'b0;
      end
      SRC_DMD:
      begin
        nxt_st.out_on = 1'b0;
        if (dmd_hit)
          nxt_st.dmd_cnt = 24'(DMD_PULSE_CYC);
      end
      default:
        nxt_st.out_on = 1'b0;
    endcase
    // read data captured in setup, presented in access
    if (rd)
    begin
      if (i_apb.paddr[7:0] == ADDR_OUT_CFG)
        nxt_st.prdata = 32'(st_ff.out_cfg);
      else if (i_apb.paddr[7:0] == ADDR_ON_TIME)
        nxt_st.prdata = 32'(st_ff.on_time);
      else if (i_apb.paddr[7:0] == ADDR_ALM_SEL)
        nxt_st.prdata = 32'(st_ff.alm_sel);
      else if (i_apb.paddr[7:0] == ADDR_IND_CFG)
        nxt_st.prdata = {24'h0, st_ff.ind_cfg[7:2], ind_mode};
      else if (i_apb.paddr[7:0] == ADDR_IND_RATE)
        nxt_st.prdata = st_ff.ind_rate;
      else if (i_apb.paddr[7:0] == ADDR_STATUS)
        nxt_st.prdata = {16'h0, st_ff.sec_left, led_pulse, o_dout_i};
      else if (i_apb.paddr[7:0] == ADDR_UNIT)
        nxt_st.prdata = st_ff.unit;
      else
        nxt_st.prdata = '0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_ff          <= '0;
      st_ff.on_time  <= RST_ON_TIME;
      st_ff.ind_rate <= RST_RATE;
      st_ff.unit     <= RST_UNIT;
    end
    else
      st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // output pin source follows the control source
  always_comb
  begin
    case (src)
      SRC_NRG: o_dout_i = dout_pulse;
      SRC_DMD: o_dout_i = (st_ff.dmd_cnt != 24'h0);
      default: o_dout_i = st_ff.out_on;
    endcase
  end
  assign o_dout       = o_dout_i;
  assign o_hold_state = st_ff.out_on;
  // off disables, alarm shows the selected alarm level, energy pulses
  assign o_led        = (ind_mode == IND_ALM) ? st_ff.alm_q :
                        led_nrg ? led_pulse : 1'b0;
  assign paddr_ok     = (i_apb.paddr[31:5] == 27'h0) && (i_apb.paddr[1:0] == 2'h0)
                        && (i_apb.paddr[7:0] != ADDR_OUT_CMD || i_apb.pwrite)
                        && (i_apb.paddr[7:0] != ADDR_STATUS || !i_apb.pwrite);
  // zero wait states; one assignment drives the whole response struct
  assign o_apb = '{prdata: st_ff.prdata, pready: 1'b1, pslverr: i_apb.psel && i_apb.penable && !paddr_ok};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_off_cmd;
    cmd_off && !cmd_on && (src == SRC_EXT || src == SRC_ALM)
    && !(src == SRC_ALM && alm_hit && !st_ff.alm_q);
  endsequence

  property p_latch_hold;
    @(posedge i_core_clk) disable iff (i_rst)
      (st_ff.out_on && beh != BEH_TIMED && (src == SRC_EXT) && !cmd_off
       && (st_ff.restored || !i_hold_valid)) |=> st_ff.out_on;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched output dropped");

  property p_off;
    @(posedge i_core_clk) disable iff (i_rst) s_off_cmd |=> !st_ff.out_on;
  endproperty
  a_off: assert property (p_off) else $error("off command ignored");

  property p_on;
    @(posedge i_core_clk) disable iff (i_rst)
      (cmd_on && src == SRC_EXT && beh != BEH_TIMED) |=> st_ff.out_on;
  endproperty
  a_on: assert property (p_on) else $error("on command ignored");

  property p_timed;
    @(posedge i_core_clk) disable iff (i_rst)
      (beh == BEH_TIMED && st_ff.out_on && st_ff.sec_left <= 14'h1 && st_ff.tick == 32'(SEC_CYC - 1)
       && !cmd_on && !alm_hit && src == SRC_EXT) |=> !st_ff.out_on;
  endproperty
  a_timed: assert property (p_timed) else $error("timed output overran");

  property p_dmd;
    @(posedge i_core_clk) disable iff (i_rst) (src == SRC_DMD && dmd_hit) |=> ##0 o_dout [*2];
  endproperty
  a_dmd: assert property (p_dmd) else $error("demand pulse missing");

  property p_led_off;
    @(posedge i_core_clk) disable iff (i_rst) (ind_mode == IND_OFF) |-> !o_led;
  endproperty
  a_led_off: assert property (p_led_off) else $error("indicator not disabled");

  property p_forced;
    @(posedge i_core_clk) disable iff (i_rst) IND_FORCED |-> led_nrg;
  endproperty
  a_forced: assert property (p_forced) else $error("indicator not forced");

  property p_ext_quiet;
    @(posedge i_core_clk) disable iff (i_rst) (src == SRC_EXT) |-> (o_dout == st_ff.out_on);
  endproperty
  a_ext_quiet: assert property (p_ext_quiet) else $error("external output pulsing");

endmodule : epoc_top

// ==== src/epoc_pkg.sv ====
// package for the energy pulse / discrete output controller: register map, fields, timing
// assumes a 20 MHz core clock and an apb master in the same clock domain
//
// What this block does
// - output in energy source is driven by pulses from the chosen energy channel
// - latched behaviour turns on and stays on until an off command
// - timed behaviour stays on for 0..9999 programmed seconds, then turns off
// - hold behaviour turns on by energize, off only by hold release
// - hold behaviour state survives control power loss and is restored
// - demand sync follows at most one demand system: power, current or input; code 3 follows none
// - alarm source responds to any of the selected alarm conditions
// - indicator modes: off disables, alarm shows alarms, energy pulses
// - energy mode emits 1..9999999 pulses per unit of energy
// - alarm mode ignores pulse rate and channel settings
// - nine selectable channels: active/reactive/apparent, del, rec, del plus rec
// - one variant forces the indicator to energy pulsing
// - external mode removes energy association, leaving remote command control
// - pulses come from measured energy for external counting
// - demand sync emits one pulse at each end of demand interval
package epoc_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_OUT_CFG  = 8'h00;
  localparam logic [7:0] ADDR_ON_TIME  = 8'h04;
  localparam logic [7:0] ADDR_ALM_SEL  = 8'h08;
  localparam logic [7:0] ADDR_OUT_CMD  = 8'h0c;
  localparam logic [7:0] ADDR_IND_CFG  = 8'h10;
  localparam logic [7:0] ADDR_IND_RATE = 8'h14;
  localparam logic [7:0] ADDR_STATUS   = 8'h18;
  localparam logic [7:0] ADDR_UNIT     = 8'h1c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OCFG_SRC_LSB  = 0;   // [1:0] control source
  localparam int OCFG_BEH_LSB  = 2;   // [3:2] behaviour
  localparam int OCFG_DMD_LSB  = 4;   // [5:4] demand system
  localparam int OCFG_CH_LSB   = 8;   // [11:8] energy channel
  localparam int CMD_ON_BIT    = 0;
  localparam int CMD_OFF_BIT   = 1;
  localparam int ICFG_MODE_LSB = 0;   // [1:0]
  localparam int ICFG_CH_LSB   = 4;   // [7:4]

  // ----------------------------------------------------------------
  // ranges, reset values and timing
  // ----------------------------------------------------------------
  localparam int          ON_TIME_MAX_S   = 9999;
  localparam int          RATE_MIN        = 1;
  localparam int          RATE_MAX        = 9999999;
  localparam int          CLK_HZ          = 20000000;
  localparam int          SEC_CYCLES      = CLK_HZ;        // cycles per second
  localparam int          DMD_PULSE_NS    = 100000000;     // demand sync pulse width, 100 ms
  localparam int          DMD_PULSE_CYC   = DMD_PULSE_NS / 50;
  localparam int          EPULSE_NS       = 10000000;      // energy pulse width, 10 ms
  localparam int          EPULSE_CYC      = EPULSE_NS / 50;
  localparam logic [31:0] RST_RATE        = 32'h0000_0001;
  localparam logic [31:0] RST_UNIT        = 32'h0010_0000; // increments per kWh
  localparam logic [13:0] RST_ON_TIME     = 14'h0000;

  // ----------------------------------------------------------------
  // enumerations and carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SRC_EXT = 2'h0, SRC_DMD = 2'h1, SRC_ALM = 2'h2, SRC_NRG = 2'h3} epoc_src_t;
  typedef enum logic [1:0] {BEH_LATCH = 2'h0, BEH_TIMED = 2'h1, BEH_HOLD = 2'h2} epoc_beh_t;
  typedef enum logic [1:0] {IND_OFF = 2'h0, IND_ALM = 2'h1, IND_NRG = 2'h2} epoc_ind_t;

  typedef struct packed {
    logic [31:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } epoc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } epoc_apb_rsp_t;

  // six channel increments: active, reactive, apparent x del, rec
  typedef struct packed {
    logic [15:0] act_del;
    logic [15:0] act_rec;
    logic [15:0] rea_del;
    logic [15:0] rea_rec;
    logic [15:0] app_del;
    logic [15:0] app_rec;
  } epoc_nrg_t;

endpackage : epoc_pkg

// ==== src/epoc_pulse_gen.sv ====
// energy pulse generator: accumulator with remainder carry and fixed pulse width
// assumes increments arrive as a per-cycle value on the core clock
module epoc_pulse_gen
  import epoc_pkg::*;
#(
  parameter int ACC_W = 48
)
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // configuration
  input  wire logic        i_en,
  input  wire logic [31:0] i_rate,
  input  wire logic [31:0] i_unit,
  input  wire logic [16:0] i_inc,
  // pulse out
  output logic             o_pulse
);

  // inc times rate needs 41 bits, and one more for the running sum
  if (ACC_W < 42)
  begin : g_bad_acc
    $error("accumulator too narrow");
  end

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [23:0]      width;
    logic             pulse;
  } epoc_pg_st_t;

  epoc_pg_st_t st_ff, nxt_st;
  logic [ACC_W-1:0] step;
  logic [ACC_W-1:0] sum;

  // ----------------------------------------------------------------
  // accumulate rate-weighted energy; one unit over rate per pulse
  // ----------------------------------------------------------------
  // scaling the increment by the rate avoids a divider; unit is compared directly
  always_comb
  begin
    step   = ACC_W'(i_inc) * ACC_W'(i_rate);
    sum    = st_ff.acc + step;
    nxt_st = st_ff;
    if (st_ff.width != 24'h0)
      nxt_st.width = st_ff.width - 24'h1;
    nxt_st.pulse = (st_ff.width > 24'h1);
    if (!i_en)
    begin
      nxt_st.acc = '0;
    end
    else if (sum >= ACC_W'(i_unit) && st_ff.width == 24'h0)
    begin
      nxt_st.acc   = sum - ACC_W'(i_unit);
      nxt_st.width = 24'(EPULSE_CYC);
      nxt_st.pulse = 1'b1;
    end
    else
    begin
      nxt_st.acc = sum;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign o_pulse = st_ff.pulse;

  property p_carry;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_en && st_ff.width == 24'h0 && sum >= ACC_W'(i_unit)) |=> st_ff.pulse;
  endproperty
  a_carry: assert property (p_carry) else $error("pulse not emitted at unit");

endmodule : epoc_pulse_gen

// ==== tb/epoc_pulse_counter.sv ====
// far-side totaliser: counts rising edges seen on one pin
// assumes the pin is sampled on the core clock
module epoc_pulse_counter
(
  // sampling
  input  wire logic i_core_clk,
  input  wire logic i_pin,
  // result
  output int        o_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_ff = 1'b0;
  initial o_count = 0;
  // a counter only sees edges, so a stuck-high pin counts once
  always @(posedge i_core_clk)
  begin
    if (i_pin === 1'b1 && prev_ff !== 1'b1)
      o_count <= o_count + 1;
    prev_ff <= i_pin;
  end
endmodule : epoc_pulse_counter

// ==== tb/epoc_top_tb.sv ====
// self-checking bench for the output and indicator controller
// assumes epoc_top with a ten-cycle second and two pulse counters
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module epoc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import epoc_pkg::*;
  logic          i_core_clk   = 1'b0;
  logic          i_rst        = 1'b1;
  epoc_apb_req_t i_apb        = '0;
  epoc_apb_rsp_t o_apb;
  epoc_nrg_t     i_nrg        = '0;
  logic [2:0]    i_dmd_end    = 3'h0;
  logic [15:0]   i_alm        = 16'h0000;
  logic          i_hold_valid = 1'b0;
  logic          i_hold_saved = 1'b0;
  logic          o_hold_state;
  logic          o_dout;
  logic          o_led;
  logic          o_led_f;
  int            failures     = 0;
  int            total_checks = 0;
  int            n_dout;
  int            n_led;
  logic [31:0]   rd;
  logic          err;

  epoc_top #(.SEC_CYC (10)) DUT (
    .i_core_clk   (i_core_clk),
    .i_rst        (i_rst),
    .i_apb        (i_apb),
    .o_apb        (o_apb),
    .i_nrg        (i_nrg),
    .i_dmd_end    (i_dmd_end),
    .i_alm        (i_alm),
    .i_hold_valid (i_hold_valid),
    .i_hold_saved (i_hold_saved),
    .o_hold_state (o_hold_state),
    .o_dout       (o_dout),
    .o_led        (o_led)
  );
  // twin built as the forced-indicator variant, sharing every input
  epoc_top #(.SEC_CYC (10), .IND_FORCED (1'b1)) u_forced (
    .i_core_clk   (i_core_clk),
    .i_rst        (i_rst),
    .i_apb        (i_apb),
    .o_apb        (),
    .i_nrg        (i_nrg),
    .i_dmd_end    (i_dmd_end),
    .i_alm        (i_alm),
    .i_hold_valid (i_hold_valid),
    .i_hold_saved (i_hold_saved),
    .o_hold_state (),
    .o_dout       (),
    .o_led        (o_led_f)
  );
  epoc_pulse_counter u_cnt_dout (.i_core_clk (i_core_clk), .i_pin (o_dout), .o_count (n_dout));
  epoc_pulse_counter u_cnt_led (.i_core_clk (i_core_clk), .i_pin (o_led), .o_count (n_led));

  // 20 MHz core clock
  initial
  begin
    forever #25 i_core_clk = ~i_core_clk;
  end

  // --------------------------------------------------------------
  // bus and helper tasks
  // --------------------------------------------------------------
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge i_core_clk);
    i_apb <= '{paddr: {24'h000000, a}, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge i_core_clk);
    i_apb.penable <= 1'b1;
    do
      @(posedge i_core_clk);
    while (o_apb.pready !== 1'b1);
    rd = o_apb.prdata;
    err = o_apb.pslverr;
    i_apb.psel <= 1'b0;
    i_apb.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic e_err);
    apb(a, 1'b0, 32'h0);
    `CHK(nm, e_err, err)
    if (!e_err) `CHK(nm, e, rd)
  endtask : rchk

  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : tick

  // reset is also the only quick way to end a long pulse
  task automatic do_reset();
    i_rst <= 1'b1;
    tick(12);
    i_rst <= 1'b0;
    tick(1);
  endtask : do_reset

  // channel k sees an increment of 10; every other field is large
  function automatic epoc_nrg_t nrg_for(input int k);
    logic [15:0] f [6];
    foreach (f[i]) f[i] = 16'h03e8;
    f[2*(k/3)]   = (k%3 == 1) ? 16'h03e8 : ((k%3 == 2) ? 16'h0005 : 16'h000a);
    f[2*(k/3)+1] = (k%3 == 0) ? 16'h03e8 : ((k%3 == 2) ? 16'h0005 : 16'h000a);
    return {f[0], f[1], f[2], f[3], f[4], f[5]};
  endfunction : nrg_for

  task automatic summarize();
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_regs();
    rchk("rate_rst", ADDR_IND_RATE, RST_RATE, 1'b0);
    rchk("unit_rst", ADDR_UNIT, RST_UNIT, 1'b0);
    rchk("ind_rst", ADDR_IND_CFG, 32'h0, 1'b0);
    wr(ADDR_ON_TIME, 32'h0000_2710);
    rchk("on_time", ADDR_ON_TIME, 32'h0000_270f, 1'b0);
    wr(ADDR_IND_RATE, 32'h0000_0000);
    rchk("rate_lo", ADDR_IND_RATE, 32'h0000_0001, 1'b0);
    wr(ADDR_IND_RATE, 32'h0098_9680);
    rchk("rate_hi", ADDR_IND_RATE, 32'h0098_967f, 1'b0);
    rchk("cmd_rd", ADDR_OUT_CMD, 32'h0, 1'b1);
    rchk("unmapped", 8'h20, 32'h0, 1'b1);
  endtask : t_regs

  task automatic t_latch();
    wr(ADDR_OUT_CMD, 32'h1);
    tick(30);
    `CHK("latch_on", 1'b1, o_dout)
    wr(ADDR_OUT_CMD, 32'h2);
    tick(2);
    `CHK("latch_off", 1'b0, o_dout)
    wr(ADDR_OUT_CFG, 32'h8);
    wr(ADDR_OUT_CMD, 32'h1);
    tick(2);
    `CHK("hold_on", 1'b1, o_dout)
    `CHK("hold_store", 1'b1, o_hold_state)
    wr(ADDR_OUT_CMD, 32'h2);
    tick(2);
    `CHK("hold_off", 1'b0, o_dout)
    // power returns with a saved on state; applied once hold is configured
    i_hold_valid <= 1'b1;
    i_hold_saved <= 1'b1;
    do_reset();
    wr(ADDR_OUT_CFG, 32'h8);
    tick(2);
    `CHK("hold_restore", 1'b1, o_dout)
    i_hold_valid <= 1'b0;
    wr(ADDR_OUT_CMD, 32'h2);
  endtask : t_latch

  // two seconds of ten cycles each
  task automatic t_timed();
    wr(ADDR_OUT_CFG, 32'h4);
    wr(ADDR_ON_TIME, 32'h2);
    wr(ADDR_OUT_CMD, 32'h1);
    tick(17);
    `CHK("timed_on", 1'b1, o_dout)
    rchk("status", ADDR_STATUS, 32'h0000_0005, 1'b0);
    tick(5);
    `CHK("timed_off", 1'b0, o_dout)
  endtask : t_timed

  task automatic t_dmd();
    for (int s = 0; s < 3; s++)
    begin
      do_reset();
      wr(ADDR_OUT_CFG, 32'h1 | (32'(s) << 4));
      i_dmd_end <= 3'h7 & ~(3'h1 << s);
      tick(1);
      i_dmd_end <= 3'h0;
      tick(4);
      `CHK("dmd_other", 1'b0, o_dout)
      i_dmd_end <= 3'h1 << s;
      tick(1);
      i_dmd_end <= 3'h0;
      tick(2);
      `CHK("dmd_pulse", 1'b1, o_dout)
    end
  endtask : t_dmd

  task automatic t_alm();
    do_reset();
    wr(ADDR_OUT_CFG, 32'h2);
    wr(ADDR_ALM_SEL, 32'h8);
    wr(ADDR_IND_CFG, 32'h0000_0001);
    wr(ADDR_UNIT, 32'h1);
    i_nrg <= '{default: 16'hffff};
    tick(5);
    `CHK("led_no_nrg", 1'b0, o_led)
    `CHK("led_forced", 1'b1, o_led_f)
    i_alm <= 16'h0001;
    tick(5);
    `CHK("alm_unsel", 1'b0, o_dout)
    i_alm <= 16'h0009;
    tick(3);
    `CHK("alm_on", 1'b1, o_dout)
    `CHK("led_alm", 1'b1, o_led)
    i_alm <= 16'h0000;
    tick(3);
    `CHK("alm_latch", 1'b1, o_dout)
    // a standing alarm must not re-latch after the off command
    i_alm <= 16'h0008;
    wr(ADDR_OUT_CMD, 32'h2);
    wr(ADDR_IND_CFG, 32'h0);
    tick(3);
    `CHK("alm_off", 1'b0, o_dout)
    `CHK("led_off", 1'b0, o_led)
    i_alm <= 16'h0000;
    i_nrg <= '0;
  endtask : t_alm

  // 3 x 10 x 3 stays under a unit of 100; the fourth cycle crosses it
  task automatic t_nrg();
    int c_d;
    int c_l;
    c_d = n_dout;
    c_l = n_led;
    for (int k = 0; k < 9; k++)
    begin
      do_reset();
      wr(ADDR_UNIT, 32'h64);
      wr(ADDR_IND_RATE, 32'h3);
      wr(ADDR_OUT_CFG, 32'h3 | (32'(k) << 8));
      wr(ADDR_IND_CFG, 32'h2 | (32'(k) << 4));
      i_nrg <= nrg_for(k);
      tick(3);
      i_nrg <= '0;
      tick(10);
      `CHK("nrg_early", 1'b0, o_dout)
      i_nrg <= nrg_for(k);
      tick(1);
      i_nrg <= '0;
      tick(10);
      `CHK("nrg_dout", 1'b1, o_dout)
      `CHK("nrg_led", 1'b1, o_led)
    end
    `CHK("dout_count", 9, n_dout - c_d)
    `CHK("led_count", 9, n_led - c_l)
    wr(ADDR_OUT_CFG, 32'h0);
    i_nrg <= '{default: 16'hffff};
    tick(10);
    `CHK("ext_quiet", 1'b0, o_dout)
    wr(ADDR_OUT_CMD, 32'h1);
    tick(2);
    `CHK("ext_cmd", 1'b1, o_dout)
    i_nrg <= '0;
  endtask : t_nrg

  // main sequence
  initial
  begin
    do_reset();
    t_regs();
    t_latch();
    t_timed();
    t_dmd();
    t_alm();
    t_nrg();
    summarize();
  end

  // hang guard, well beyond the roughly 730 cycles the run needs
  initial
  begin
    repeat (50000) @(posedge i_core_clk);
    failures++;
    summarize();
  end
endmodule : epoc_top_tb
